//--- shared/sacc_consts.vh
// Register offsets, field positions, reset values and timing counts of the converter control block
`ifndef SACC_CONSTS_VH
`define SACC_CONSTS_VH
`define SACC_CFG_ADDR 8'hBC
`define SACC_CTL_ADDR 8'hE8
`define SACC_IST_ADDR 8'hF0
`define SACC_IMK_ADDR 8'hF4
`define SACC_RES_ADDR 8'hF8
`define SACC_CFG_RST 8'h60
`define SACC_CTL_RST 8'h00
`define SACC_CFG_DIV_HI 7
`define SACC_CFG_DIV_LO 5
`define SACC_CFG_GAIN_HI 2
`define SACC_CFG_GAIN_LO 0
`define SACC_CTL_EN 7
`define SACC_CTL_TM 6
`define SACC_CTL_DONE 5
`define SACC_CTL_BUSY 4
`define SACC_CTL_SRC_HI 3
`define SACC_CTL_SRC_LO 2
`define SACC_CTL_WIN 1
`define SACC_CTL_LJ 0
`define SACC_SRC_SW 2'h0
`define SACC_SRC_T2 2'h3
`define SACC_TRACK_CLKS 5'h03
`define SACC_CONV_CLKS 5'h0C
`define SACC_RESP_OKAY 2'h0
`define SACC_RESP_SLVERR 2'h2
`endif

//--- src/sacc_top.v
// Converter control and configuration logic with an AXI4-Lite register slave
// Overview of operation
// RULE1: Converter clock is system clock divided by 1,2,4,8,16 from the divide field.
// RULE2: Configuration bits 4 and 3 read zero and ignore writes.
// RULE3: Gain field maps 000..011 to gains 1..8 and 10x to 16.
// RULE4: Enable low holds converter in shutdown; high makes it accept requests.
// RULE5: Track mode 0 tracks continuously except during conversion.
// RULE6: Track mode 1 tracks three converter clocks after a trigger, then converts.
// RULE7: Completion flag sets when conversion ends and only software clears it.
// RULE8: Busy reads high during conversion; its fall sets completion and interrupts.
// RULE9: Writing busy 0 does nothing; 1 starts only with software start source.
// RULE10: Start source 00 is software write, 11 is timer 2 overflow.
// RULE11: Window flag sets on a matching result and stays until software clears it.
// RULE12: Justify bit selects right or left placement of the twelve-bit result.
// RULE13: Triggers during a running conversion are ignored.
//
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ns
`include "sacc_consts.vh"
module sacc_top #(
	parameter RES_W = 12,
	parameter CONV_CLKS = 12
) (
	clk_sys,
	sys_rst,
	s_axi_awaddr,
	s_axi_awvalid,
	s_axi_awready,
	s_axi_wdata,
	s_axi_wstrb,
	s_axi_wvalid,
	s_axi_wready,
	s_axi_bresp,
	s_axi_bvalid,
	s_axi_bready,
	s_axi_araddr,
	s_axi_arvalid,
	s_axi_arready,
	s_axi_rdata,
	s_axi_rresp,
	s_axi_rvalid,
	s_axi_rready,
	timer2_overflow,
	sar_result,
	window_match,
	conv_tick,
	track_active,
	convert_active,
	shutdown,
	pga_gain,
	irq
);
	input wire clk_sys;
	input wire sys_rst;
	input wire [7:0] s_axi_awaddr;
	input wire s_axi_awvalid;
	output wire s_axi_awready;
	input wire [31:0] s_axi_wdata;
	input wire [3:0] s_axi_wstrb;
	input wire s_axi_wvalid;
	output wire s_axi_wready;
	output reg [1:0] s_axi_bresp;
	output reg s_axi_bvalid;
	input wire s_axi_bready;
	input wire [7:0] s_axi_araddr;
	input wire s_axi_arvalid;
	output wire s_axi_arready;
	output reg [31:0] s_axi_rdata;
	output reg [1:0] s_axi_rresp;
	output reg s_axi_rvalid;
	input wire s_axi_rready;
	input wire timer2_overflow;
	input wire [11:0] sar_result;
	input wire window_match;
	output reg conv_tick;
	output reg track_active;
	output reg convert_active;
	output reg shutdown;
	output reg [4:0] pga_gain;
	output wire irq;

	localparam ST_IDLE = 3'b001;
	localparam ST_TRACK = 3'b010;
	localparam ST_CONV = 3'b100;

	reg [7:0] cfg_reg;
	reg [7:0] ctl_reg;
	reg [1:0] ist_reg;
	reg [1:0] imk_reg;
	reg [15:0] res_reg;
	reg [2:0] state_reg;
	reg [4:0] sar_cnt_reg;
	reg [3:0] div_cnt_reg;
	reg busy_reg;
	reg t2_s1_reg;
	reg t2_s2_reg;
	reg t2_s3_reg;
	reg win_s1_reg;
	reg win_s2_reg;
	reg [11:0] res_s1_reg;
	reg [11:0] res_s2_reg;
	reg aw_got_reg;
	reg w_got_reg;
	reg [7:0] aw_addr_reg;
	reg [31:0] w_data_reg;
	reg [3:0] w_strb_reg;
	reg [3:0] div_max;
	reg [7:0] wdat;
	wire wr_go;
	wire [7:0] wa;
	wire [31:0] wd;
	wire [3:0] ws;
	wire ctl_wr;
	wire sw_start;
	wire t2_edge;
	wire trig;
	wire done_pulse;
	wire set_win;

	// Timer and result come from another timing domain
	always @(posedge clk_sys) begin
		if (sys_rst) begin
			t2_s1_reg <= 1'b0;
			t2_s2_reg <= 1'b0;
			t2_s3_reg <= 1'b0;
			win_s1_reg <= 1'b0;
			win_s2_reg <= 1'b0;
			res_s1_reg <= 12'h000;
			res_s2_reg <= 12'h000;
		end else begin
			t2_s1_reg <= timer2_overflow;
			t2_s2_reg <= t2_s1_reg;
			t2_s3_reg <= t2_s2_reg;
			win_s1_reg <= window_match;
			win_s2_reg <= win_s1_reg;
			res_s1_reg <= sar_result;
			res_s2_reg <= res_s1_reg;
		end
	end
	assign t2_edge = t2_s2_reg & ~t2_s3_reg;

	// Write side: address and data are taken independently, in either order
	assign s_axi_awready = ~aw_got_reg & ~s_axi_bvalid;
	assign s_axi_wready = ~w_got_reg & ~s_axi_bvalid;
	assign wa = aw_got_reg ? aw_addr_reg : s_axi_awaddr;
	assign wd = w_got_reg ? w_data_reg : s_axi_wdata;
	assign ws = w_got_reg ? w_strb_reg : s_axi_wstrb;
	assign wr_go = (aw_got_reg | (s_axi_awvalid & s_axi_awready)) & (w_got_reg | (s_axi_wvalid & s_axi_wready));
	always @* begin
		wdat = wd[7:0];
	end

	always @(posedge clk_sys) begin
		if (sys_rst) begin
			aw_got_reg <= 1'b0;
			w_got_reg <= 1'b0;
			aw_addr_reg <= 8'h00;
			w_data_reg <= 32'h00000000;
			w_strb_reg <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `SACC_RESP_OKAY;
		end else begin
			if (s_axi_bvalid & s_axi_bready)
				s_axi_bvalid <= 1'b0;
			if (wr_go) begin
				aw_got_reg <= 1'b0;
				w_got_reg <= 1'b0;
				s_axi_bvalid <= 1'b1;
				case ({wa[7:2], 2'b00})
				`SACC_CFG_ADDR, `SACC_CTL_ADDR, `SACC_IST_ADDR, `SACC_IMK_ADDR, `SACC_RES_ADDR: begin
					s_axi_bresp <= `SACC_RESP_OKAY;
				end
				default: begin
					s_axi_bresp <= `SACC_RESP_SLVERR;
				end
				endcase
			end else begin
				if (s_axi_awvalid & s_axi_awready) begin
					aw_got_reg <= 1'b1;
					aw_addr_reg <= s_axi_awaddr;
				end
				if (s_axi_wvalid & s_axi_wready) begin
					w_got_reg <= 1'b1;
					w_data_reg <= s_axi_wdata;
					w_strb_reg <= s_axi_wstrb;
				end
			end
		end
	end

	assign ctl_wr = wr_go & ws[0] & ({wa[7:2], 2'b00} == `SACC_CTL_ADDR);
	assign sw_start = ctl_wr & wdat[`SACC_CTL_BUSY] & wdat[`SACC_CTL_EN]
		& (wdat[`SACC_CTL_SRC_HI:`SACC_CTL_SRC_LO] == `SACC_SRC_SW); // RULE9
	assign trig = (sw_start | (t2_edge & (ctl_reg[`SACC_CTL_SRC_HI:`SACC_CTL_SRC_LO] == `SACC_SRC_T2)))
		& ctl_reg[`SACC_CTL_EN] & (state_reg == ST_IDLE); // RULE10 RULE13 RULE4

	// Converter clock divider
	always @* begin
		case (cfg_reg[`SACC_CFG_DIV_HI:`SACC_CFG_DIV_LO])
		3'h0: div_max = 4'h0;
		3'h1: div_max = 4'h1;
		3'h2: div_max = 4'h3;
		3'h3: div_max = 4'h7;
		default: div_max = 4'hF;
		endcase
	end
	always @(posedge clk_sys) begin
		if (sys_rst) begin
			div_cnt_reg <= 4'h0;
			conv_tick <= 1'b0;
		end else if (div_cnt_reg >= div_max) begin
			div_cnt_reg <= 4'h0;
			conv_tick <= 1'b1; // RULE1
		end else begin
			div_cnt_reg <= div_cnt_reg + 4'h1;
			conv_tick <= 1'b0;
		end
	end

	// Conversion sequencer; counts converter clocks
	always @(posedge clk_sys) begin
		if (sys_rst | ~ctl_reg[`SACC_CTL_EN]) begin
			state_reg <= ST_IDLE;
			sar_cnt_reg <= 5'h00;
		end else begin
			case (state_reg)
			ST_IDLE: begin
				if (trig & ctl_reg[`SACC_CTL_TM]) begin
					state_reg <= ST_TRACK; // RULE6
					sar_cnt_reg <= `SACC_TRACK_CLKS;
				end else if (trig) begin
					state_reg <= ST_CONV;
					sar_cnt_reg <= CONV_CLKS[4:0];
				end
			end
			ST_TRACK: begin
				if (conv_tick) begin
					if (sar_cnt_reg == 5'h01) begin
						state_reg <= ST_CONV; // RULE6
						sar_cnt_reg <= CONV_CLKS[4:0];
					end else
						sar_cnt_reg <= sar_cnt_reg - 5'h01;
				end
			end
			ST_CONV: begin
				if (conv_tick) begin
					if (sar_cnt_reg == 5'h01)
						state_reg <= ST_IDLE;
					else
						sar_cnt_reg <= sar_cnt_reg - 5'h01;
				end
			end
			default: begin
				state_reg <= ST_IDLE;
			end
			endcase
		end
	end

	// Busy covers tracking triggered by a start as well as the conversion
	always @(posedge clk_sys) begin
		if (sys_rst) begin
			busy_reg <= 1'b0;
			shutdown <= 1'b1;
			track_active <= 1'b0;
			convert_active <= 1'b0;
			pga_gain <= 5'h01;
		end else begin
			busy_reg <= (state_reg != ST_IDLE); // RULE8
			shutdown <= ~ctl_reg[`SACC_CTL_EN]; // RULE4
			// Gated by enable so it falls together with the rise of shutdown
			convert_active <= ctl_reg[`SACC_CTL_EN] & (state_reg == ST_CONV); // RULE4
			track_active <= ctl_reg[`SACC_CTL_EN] & ((state_reg == ST_TRACK)
				| (~ctl_reg[`SACC_CTL_TM] & (state_reg == ST_IDLE))); // RULE5
			case (cfg_reg[`SACC_CFG_GAIN_HI:`SACC_CFG_GAIN_LO]) // RULE3
			3'h0: pga_gain <= 5'h01;
			3'h1: pga_gain <= 5'h02;
			3'h2: pga_gain <= 5'h04;
			3'h3: pga_gain <= 5'h08;
			3'h4, 3'h5: pga_gain <= 5'h10;
			default: pga_gain <= 5'h01;
			endcase
		end
	end
	assign done_pulse = busy_reg & (state_reg == ST_IDLE) & ctl_reg[`SACC_CTL_EN]; // RULE8
	assign set_win = done_pulse & win_s2_reg; // RULE11

	// Registers; hardware set beats a software clear in the same cycle
	always @(posedge clk_sys) begin
		if (sys_rst) begin
			cfg_reg <= `SACC_CFG_RST;
			ctl_reg <= `SACC_CTL_RST;
			ist_reg <= 2'b00;
			imk_reg <= 2'b00;
			res_reg <= 16'h0000;
		end else begin
			if (wr_go & ws[0] & ({wa[7:2], 2'b00} == `SACC_CFG_ADDR))
				cfg_reg <= {wdat[7:5], 2'b00, wdat[2:0]}; // RULE2 RULE1
			if (ctl_wr) begin
				ctl_reg[`SACC_CTL_EN] <= wdat[`SACC_CTL_EN];
				ctl_reg[`SACC_CTL_TM] <= wdat[`SACC_CTL_TM];
				ctl_reg[`SACC_CTL_SRC_HI:`SACC_CTL_SRC_LO] <= wdat[`SACC_CTL_SRC_HI:`SACC_CTL_SRC_LO];
				ctl_reg[`SACC_CTL_LJ] <= wdat[`SACC_CTL_LJ];
				ctl_reg[`SACC_CTL_DONE] <= wdat[`SACC_CTL_DONE] | done_pulse; // RULE7
				ctl_reg[`SACC_CTL_WIN] <= wdat[`SACC_CTL_WIN] | set_win; // RULE11
			end else begin
				if (done_pulse)
					ctl_reg[`SACC_CTL_DONE] <= 1'b1; // RULE7
				if (set_win)
					ctl_reg[`SACC_CTL_WIN] <= 1'b1;
			end
			ctl_reg[`SACC_CTL_BUSY] <= 1'b0;
			if (wr_go & ws[0] & ({wa[7:2], 2'b00} == `SACC_IST_ADDR))
				ist_reg <= (ist_reg & ~wdat[1:0]) | {set_win, done_pulse};
			else
				ist_reg <= ist_reg | {set_win, done_pulse};
			if (wr_go & ws[0] & ({wa[7:2], 2'b00} == `SACC_IMK_ADDR))
				imk_reg <= wdat[1:0];
			if (done_pulse) begin
				if (ctl_reg[`SACC_CTL_LJ])
					res_reg <= {res_s2_reg, 4'h0}; // RULE12
				else
					res_reg <= {4'h0, res_s2_reg}; // RULE12
			end
		end
	end
	assign irq = |(ist_reg & imk_reg); // RULE8

	// Read side: one read at a time, answered one cycle after the address is taken
	assign s_axi_arready = ~s_axi_rvalid;
	always @(posedge clk_sys) begin
		if (sys_rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `SACC_RESP_OKAY;
		end else if (s_axi_rvalid) begin
			if (s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end else if (s_axi_arvalid) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= `SACC_RESP_OKAY;
			case ({s_axi_araddr[7:2], 2'b00})
			`SACC_CFG_ADDR: s_axi_rdata <= {24'h000000, cfg_reg};
			`SACC_CTL_ADDR: s_axi_rdata <= {24'h000000, ctl_reg[7:5], busy_reg, ctl_reg[3:0]}; // RULE8
			`SACC_IST_ADDR: s_axi_rdata <= {30'h00000000, ist_reg};
			`SACC_IMK_ADDR: s_axi_rdata <= {30'h00000000, imk_reg};
			`SACC_RES_ADDR: s_axi_rdata <= {16'h0000, res_reg};
			default: begin
				s_axi_rdata <= 32'h00000000;
				s_axi_rresp <= `SACC_RESP_SLVERR;
			end
			endcase
		end
	end
endmodule

//--- testbench/sacc_front_model.sv
// Analog front-end stand-in giving a sample level and window verdict
`timescale 1ns/1ns
module sacc_front_model (
	input wire track_active,
	input wire convert_active,
	input wire [11:0] lvl,
	input wire win,
	output wire [11:0] sar_result,
	output wire window_match
);
	// Outside sampling the lines carry the inverse, so a late capture shows up
	assign sar_result = (track_active || convert_active) ? lvl : ~lvl;
	assign window_match = (track_active || convert_active) ? win : ~win;
endmodule

//--- testbench/sacc_top_asserts.sv
// Port-level assertions for the converter control block
`timescale 1ns/1ns
module sacc_top_chk (
	input wire clk_sys,
	input wire sys_rst,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire [31:0] s_axi_rdata,
	input wire track_active,
	input wire convert_active,
	input wire shutdown,
	input wire [4:0] pga_gain
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	chk_bvalid_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("bvalid dropped");
	chk_rvalid_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("rvalid dropped");
	chk_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read address taken early");
	chk_read_answer: assert property ($rose(s_axi_rvalid) |-> $past(s_axi_arvalid && s_axi_arready))
		else $error("read answer without a taken address");
	chk_shutdown_idle: assert property (shutdown |-> !convert_active && !track_active)
		else $error("activity in shutdown");
	chk_track_convert: assert property (convert_active |-> !track_active)
		else $error("tracking while converting");
	chk_gain_onehot: assert property ($onehot(pga_gain))
		else $error("gain not one-hot");
	chk_reset_state: assert property ($fell(sys_rst) |-> shutdown && pga_gain == 5'h01)
		else $error("bad state after reset");
	chk_convert_span: assert property ($rose(convert_active) |-> convert_active[*8])
		else $error("conversion too short");
endmodule
bind sacc_top sacc_top_chk u_sacc_top_chk (.*);

//--- testbench/test_sacc_top.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ns
`include "sacc_consts.vh"
module test_sacc_top;
	reg clk_sys = 1'b0;
	reg sys_rst = 1'b1;
	reg [7:0] s_axi_awaddr = 8'h00;
	reg [7:0] s_axi_araddr = 8'h00;
	reg [31:0] s_axi_wdata = 32'h0;
	reg [3:0] s_axi_wstrb = 4'hF;
	reg s_axi_awvalid = 1'b0;
	reg s_axi_wvalid = 1'b0;
	reg s_axi_arvalid = 1'b0;
	reg s_axi_bready = 1'b1;
	reg s_axi_rready = 1'b1;
	reg timer2_overflow = 1'b0;
	reg win = 1'b0;
	reg [11:0] lvl = 12'h0;
	reg [31:0] rv;
	reg [1:0] rr;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire [11:0] sar_result;
	wire [4:0] pga_gain;
	wire window_match, conv_tick, track_active, convert_active, shutdown, irq;
	integer mismatches = 0;
	integer n_checks = 0;
	integer seed = 94;
	integer i, d, k, n, rnd;
	sacc_top u_sacc_top (.*);
	sacc_front_model u_sacc_front_model (.*);
	always #20 clk_sys = ~clk_sys;
	function [4:0] gain(input [2:0] c);
		gain = c[2] ? (c[1] ? 5'h01 : 5'h10) : (5'h01 << c[1:0]);
	endfunction
	task summarize;
		begin
			$display("checks %0d mismatches %0d", n_checks, mismatches);
			if (mismatches == 0 && n_checks > 0)
				$display("bench passed");
			else
				$display("bench failed");
			$finish;
		end
	endtask
	task chk(input [31:0] got, input [31:0] exp);
		begin
			n_checks = n_checks + 1;
			if (got !== exp) begin
				mismatches = mismatches + 1;
				$display("ERROR %0t got %h expected %h", $time, got, exp);
			end
		end
	endtask
	task tmo(input integer t);
		begin
			if (t == 999) begin
				mismatches = mismatches + 1;
				$display("ERROR %0t wait timed out", $time);
				summarize;
			end
		end
	endtask
	task wr(input [7:0] a, input [7:0] v, input [1:0] r);
		integer j;
		begin
			s_axi_awaddr <= a;
			s_axi_wdata <= {24'h0, v};
			s_axi_awvalid <= 1'b1;
			s_axi_wvalid <= 1'b1;
			for (j = 0; j < 999; j = j + 1) begin
				@(posedge clk_sys);
				if (s_axi_awready) s_axi_awvalid <= 1'b0;
				if (s_axi_wready) s_axi_wvalid <= 1'b0;
				if (s_axi_bvalid) begin
					chk(s_axi_bresp, r);
					j = 1000;
				end
			end
			tmo(j);
		end
	endtask
	task rd(input [7:0] a);
		integer j;
		begin
			s_axi_araddr <= a;
			s_axi_arvalid <= 1'b1;
			for (j = 0; j < 999; j = j + 1) begin
				@(posedge clk_sys);
				if (s_axi_arready) s_axi_arvalid <= 1'b0;
				if (s_axi_rvalid) begin
					rv = s_axi_rdata;
					rr = s_axi_rresp;
					j = 1000;
				end
			end
			tmo(j);
		end
	endtask
	// Waits for the interrupt while counting tracking cycles
	task wt;
		integer j;
		begin
			n = 0;
			for (j = 0; j < 999; j = j + 1) begin
				@(posedge clk_sys);
				n = n + track_active;
				if (irq === 1'b1) j = 1000;
			end
			tmo(j);
		end
	endtask
	task go(input [7:0] c, input w);
		begin
			rnd = $random(seed);
			lvl <= rnd[11:0];
			win <= w;
			// Enable must already stand before a start strobe is taken
			wr(`SACC_CTL_ADDR, c & 8'hEF, `SACC_RESP_OKAY);
			wr(`SACC_CTL_ADDR, c, `SACC_RESP_OKAY);
		end
	endtask
	initial begin
		repeat (16) @(posedge clk_sys);
		sys_rst <= 1'b0;
		rd(`SACC_CFG_ADDR);
		chk(rv, `SACC_CFG_RST);
		rd(`SACC_CTL_ADDR);
		chk(rv, `SACC_CTL_RST);
		for (i = 0; i < 8; i = i + 1) begin
			d = (i < 5) ? i : 0;
			wr(`SACC_CFG_ADDR, {d[2:0], 2'b11, i[2:0]}, `SACC_RESP_OKAY);
			rd(`SACC_CFG_ADDR);
			chk(rv, {d[2:0], 2'b00, i[2:0]});
			chk(pga_gain, gain(i[2:0]));
			k = 0;
			repeat (32) @(posedge clk_sys) k = k + conv_tick;
			chk(k, 32 >> d);
		end
		wr(8'h10, 8'hFF, `SACC_RESP_SLVERR);
		rd(8'h10);
		chk(rr, `SACC_RESP_SLVERR);
		chk(rv, 32'h0);
		wr(`SACC_IMK_ADDR, 8'h03, `SACC_RESP_OKAY);
		go(8'h90, 1'b0);
		rd(`SACC_CTL_ADDR);
		chk(rv[4], 1'b1);
		chk({convert_active, track_active}, 2'b10);
		wt;
		chk(track_active, 1'b1);
		rd(`SACC_CTL_ADDR);
		chk(rv, 32'hA0);
		rd(`SACC_RES_ADDR);
		chk(rv, lvl);
		wr(`SACC_IST_ADDR, 8'h01, `SACC_RESP_OKAY);
		chk(irq, 1'b0);
		// A second start lands while the first conversion still runs
		wr(`SACC_CTL_ADDR, 8'h90, `SACC_RESP_OKAY);
		wr(`SACC_CTL_ADDR, 8'h90, `SACC_RESP_OKAY);
		wt;
		wr(`SACC_IST_ADDR, 8'h03, `SACC_RESP_OKAY);
		repeat (40) @(posedge clk_sys);
		chk(irq, 1'b0);
		go(8'hCD, 1'b1);
		timer2_overflow <= 1'b1;
		wt;
		timer2_overflow <= 1'b0;
		chk(n, `SACC_TRACK_CLKS);
		chk(track_active, 1'b0);
		rd(`SACC_CTL_ADDR);
		chk(rv, 32'hEF);
		rd(`SACC_RES_ADDR);
		chk(rv, {lvl, 4'h0});
		wr(`SACC_IST_ADDR, 8'h03, `SACC_RESP_OKAY);
		for (i = 0; i < 4; i = i + 1) begin
			d = (i == 0) ? 8'h80 : 8'h90 + 4 * i;
			wr(`SACC_CTL_ADDR, d[7:0], `SACC_RESP_OKAY);
			timer2_overflow <= (i < 3);
			repeat (40) @(posedge clk_sys);
			chk(irq, 1'b0);
			timer2_overflow <= 1'b0;
		end
		wr(`SACC_IMK_ADDR, 8'h00, `SACC_RESP_OKAY);
		go(8'h90, 1'b0);
		repeat (60) @(posedge clk_sys);
		chk(irq, 1'b0);
		wr(`SACC_IMK_ADDR, 8'h01, `SACC_RESP_OKAY);
		chk(irq, 1'b1);
		wr(`SACC_IST_ADDR, 8'h03, `SACC_RESP_OKAY);
		go(8'h10, 1'b0);
		repeat (60) @(posedge clk_sys);
		chk({shutdown, irq}, 2'b10);
		summarize;
	end
endmodule
